// ==== src/spm_serial_top.sv ====
// serial port unit: bus slave, async and clocked sync engines, pin muxing
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
// How it works
// - module stop holds unit halted after reset
// - break input keeps setting framing error flag
// - txd follows port settings while tx disabled
// - clearing tx enable resets transmitter at once
// - sync mode: no transmit while error flags set
// - rx enable clear keeps error flags
// - low power resets tx registers and status
// - low power: port drives pin, then mark
// - low power resets rx registers and status
// - sync with sck driven out to port switch drives sck low briefly
// - dma write clears tx empty flag
// - any receive error raises error request
module spm_serial_top (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte lanes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write answer
  output logic bvalid, // write answer valid
  input wire logic bready, // write answer ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read answer
  output logic rvalid, // read answer valid
  input wire logic rready, // read answer ready
  input wire logic low_power_req, // standby, watch or sub-clock mode active
  input wire logic dma_tx_wr, // dma write strobe to tx holding
  input wire logic [7:0] dma_tx_data, // dma write data
  input wire logic dma_rx_rd, // dma read strobe of rx holding
  output logic [7:0] dma_rx_data, // rx holding contents
  output logic tx_empty_request, // tx holding empty request
  output logic tx_end_request, // transmission end request
  output logic rx_full_request, // rx data full request
  output logic rx_error_request, // receive error request
  output logic txd_o, // txd pin level
  output logic txd_oe, // txd pin driven
  input wire logic rxd_i, // rxd pin level
  input wire logic sck_i, // sck pin level
  output logic sck_o, // sck pin level out
  output logic sck_oe // sck pin driven
);
  // byte-lane merge, used by the control and status registers
  function automatic logic [31:0] spm_wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : spm_wmerge

  // decode: mapped, and only the stop register while stopped
  function automatic logic spm_reg_ok(input logic [7:0] a, input logic stopped);
    case (a)
      spm_pkg::OFS_STOP: spm_reg_ok = 1'b1;
      spm_pkg::OFS_CTRL, spm_pkg::OFS_STAT, spm_pkg::OFS_TXD, spm_pkg::OFS_RXD,
      spm_pkg::OFS_PORT, spm_pkg::OFS_BAUD: spm_reg_ok = !stopped;
      default: spm_reg_ok = 1'b0;
    endcase
  endfunction : spm_reg_ok

  logic mstop_reg; // module stop
  logic lp_act; // stopped or low power
  spm_pkg::spm_ctrl_s ctrl_reg; // control
  spm_pkg::spm_status_s stat_reg; // status flags
  spm_pkg::spm_port_s port_reg; // pin port settings
  logic [7:0] baud_reg; // half-bit divider
  logic [7:0] tx_holding_reg, rx_holding_reg, tx_shift_reg, rx_shift_reg;
  logic aw_have_reg, w_have_reg; // bus halves held
  logic [7:0] aw_addr_reg; // held write address
  logic [31:0] w_data_reg; // held write data
  logic [3:0] w_strb_reg; // held byte lanes
  logic wr_fire, wr_ok; // write executes this cycle
  logic [31:0] rd_mux; // read value
  spm_pkg::spm_tx_e tx_st_reg; // transmitter state
  spm_pkg::spm_rx_e rx_st_reg; // receiver state
  logic tx_line_reg, tx_ph_reg, tx_par_reg; // line level, half phase, parity
  logic [2:0] tx_cnt_reg, rx_cnt_reg; // bit counters
  logic [7:0] div_reg, rdiv_reg; // half-bit dividers
  logic rx_ph_reg, rx_perr_reg, sck_prev_reg; // rx phase, parity error, last sck
  logic glitch_reg; // sck low pulse active
  logic [7:0] glitch_cnt_reg; // sck low pulse length
  logic half_tick, rx_ht, ext_clk, tx_adv, tx_go, tx_done, err_any;
  logic rx_samp, rx_fin, rx_fer_ev, rx_per_ev, rx_store, glitch_trig;
  logic [7:0] rx_word; // completed receive byte
  logic [31:0] wv_ctrl, wv_stat; // merged write values
  spm_pkg::spm_status_s sts_clr; // flags cleared by software

  assign lp_act = mstop_reg | low_power_req;
  assign err_any = stat_reg.overrun_flag | stat_reg.parity_error_flag
                 | stat_reg.framing_error_flag;

  // bus write side: either half may come first; answer after both
  assign awready = !aw_have_reg && !bvalid;
  assign wready = !w_have_reg && !bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
  assign wr_ok = wr_fire && spm_reg_ok(aw_addr_reg, mstop_reg);
  assign wv_ctrl = spm_wmerge({23'h0, ctrl_reg}, w_data_reg, w_strb_reg);
  assign wv_stat = spm_wmerge({26'h0, stat_reg}, w_data_reg, w_strb_reg);
  assign sts_clr = spm_pkg::spm_status_s'((wr_ok && aw_addr_reg == spm_pkg::OFS_STAT) ?
                   (~wv_stat[spm_pkg::STAT_W-1:0] & spm_pkg::STAT_CLR_MASK) : 6'h00);

  // write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= spm_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read value mux; the port word also shows live pin levels
  always_comb begin
    rd_mux = 32'h0;
    case (araddr)
      spm_pkg::OFS_STOP: rd_mux = {31'h0, mstop_reg};
      spm_pkg::OFS_CTRL: rd_mux = {23'h0, ctrl_reg};
      spm_pkg::OFS_STAT: rd_mux = {26'h0, stat_reg};
      spm_pkg::OFS_TXD: rd_mux = {24'h0, tx_holding_reg};
      spm_pkg::OFS_RXD: rd_mux = {24'h0, rx_holding_reg};
      spm_pkg::OFS_PORT: rd_mux = {26'h0, rxd_i, txd_o, port_reg};
      spm_pkg::OFS_BAUD: rd_mux = {24'h0, baud_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= spm_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= spm_reg_ok(araddr, mstop_reg) ? rd_mux : 32'h0;
      rresp <= spm_reg_ok(araddr, mstop_reg) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // configuration registers; module stop starts set so the unit is halted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mstop_reg <= 1'b1;
      ctrl_reg <= spm_pkg::CTRL_RST;
      port_reg <= spm_pkg::PORT_RST;
      baud_reg <= spm_pkg::BAUD_RST;
    end else if (wr_ok) begin
      case (aw_addr_reg)
        spm_pkg::OFS_STOP: if (w_strb_reg[0]) mstop_reg <= w_data_reg[0];
        spm_pkg::OFS_CTRL: ctrl_reg <= spm_pkg::spm_ctrl_s'(wv_ctrl[spm_pkg::CTRL_W-1:0]);
        spm_pkg::OFS_PORT: if (w_strb_reg[0]) port_reg <= spm_pkg::spm_port_s'(w_data_reg[3:0]);
        spm_pkg::OFS_BAUD: if (w_strb_reg[0]) baud_reg <= w_data_reg[7:0];
        default: mstop_reg <= mstop_reg;
      endcase
    end
  end

  // transmit holding: dma has priority over the bus
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_act) begin
      tx_holding_reg <= 8'h00;
    end else if (dma_tx_wr) begin
      tx_holding_reg <= dma_tx_data;
    end else if (wr_ok && aw_addr_reg == spm_pkg::OFS_TXD && w_strb_reg[0]) begin
      tx_holding_reg <= w_data_reg[7:0];
    end
  end

  // clock events: internal half ticks or external sck edges
  assign half_tick = (tx_st_reg != spm_pkg::TX_IDLE) && (div_reg == baud_reg);
  assign ext_clk = ctrl_reg.sync_mode && ctrl_reg.clock_source_select;
  assign tx_adv = ext_clk ? (sck_prev_reg && !sck_i) : (half_tick && tx_ph_reg);
  assign tx_go = (tx_st_reg == spm_pkg::TX_IDLE) && ctrl_reg.tx_enable_bit && !lp_act
                 && !stat_reg.tx_empty_flag && !(ctrl_reg.sync_mode && err_any);
  assign tx_done = tx_adv && ((tx_st_reg == spm_pkg::TX_STOP) || (ctrl_reg.sync_mode
                   && tx_st_reg == spm_pkg::TX_DATA && tx_cnt_reg == spm_pkg::LAST_BIT));

  // divider restarts every frame so bits line up with the start
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_st_reg == spm_pkg::TX_IDLE) begin
      div_reg <= 8'h00;
      tx_ph_reg <= 1'b0;
    end else if (half_tick) begin
      div_reg <= 8'h00;
      tx_ph_reg <= !tx_ph_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
    sck_prev_reg <= aresetn ? sck_i : 1'b1;
  end

  // transmitter; dropping tx enable aborts any frame immediately
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_act || !ctrl_reg.tx_enable_bit) begin
      tx_st_reg <= spm_pkg::TX_IDLE;
      tx_line_reg <= 1'b1;
      tx_shift_reg <= 8'h00;
      tx_cnt_reg <= 3'h0;
      tx_par_reg <= 1'b0;
    end else begin
      case (tx_st_reg)
        spm_pkg::TX_IDLE: if (tx_go) begin
          tx_shift_reg <= tx_holding_reg;
          tx_par_reg <= ^tx_holding_reg;
          tx_cnt_reg <= 3'h0;
          tx_line_reg <= ctrl_reg.sync_mode ? tx_holding_reg[0] : 1'b0;
          tx_st_reg <= ctrl_reg.sync_mode ? spm_pkg::TX_DATA : spm_pkg::TX_START;
        end
        spm_pkg::TX_START: if (tx_adv) begin
          tx_line_reg <= tx_shift_reg[0];
          tx_st_reg <= spm_pkg::TX_DATA;
        end
        spm_pkg::TX_DATA: if (tx_adv) begin
          if (tx_cnt_reg == spm_pkg::LAST_BIT) begin
            tx_line_reg <= ctrl_reg.parity_enable && !ctrl_reg.sync_mode ? tx_par_reg : 1'b1;
            if (ctrl_reg.sync_mode) tx_st_reg <= spm_pkg::TX_IDLE;
            else if (ctrl_reg.parity_enable) tx_st_reg <= spm_pkg::TX_PAR;
            else tx_st_reg <= spm_pkg::TX_STOP;
          end else begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_line_reg <= tx_shift_reg[1];
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
          end
        end
        spm_pkg::TX_PAR: if (tx_adv) begin
          tx_line_reg <= 1'b1;
          tx_st_reg <= spm_pkg::TX_STOP;
        end
        spm_pkg::TX_STOP: if (tx_adv) tx_st_reg <= spm_pkg::TX_IDLE;
        default: tx_st_reg <= spm_pkg::TX_IDLE;
      endcase
    end
  end

  // receive sampling: async at mid bit, sync on rising sck
  assign rx_ht = (rx_st_reg != spm_pkg::RX_IDLE) && (rdiv_reg == baud_reg);
  assign rx_samp = !ctrl_reg.sync_mode ? (rx_ht && !rx_ph_reg) : ext_clk ?
                   (!sck_prev_reg && sck_i) : (half_tick && !tx_ph_reg);
  assign rx_word = ctrl_reg.sync_mode ? {rxd_i, rx_shift_reg[7:1]} : rx_shift_reg;
  assign rx_fin = rx_samp && (ctrl_reg.sync_mode ? (rx_st_reg == spm_pkg::RX_DATA
                  && rx_cnt_reg == spm_pkg::LAST_BIT) : rx_st_reg == spm_pkg::RX_STOP);
  assign rx_fer_ev = rx_fin && !ctrl_reg.sync_mode && !rxd_i;
  assign rx_per_ev = rx_fin && !ctrl_reg.sync_mode && rx_perr_reg;
  assign rx_store = rx_fin && !stat_reg.rx_full_flag && !rx_fer_ev && !rx_per_ev;

  // receiver; after a frame it rearms at once, so a held break refires
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_act || !ctrl_reg.rx_enable_bit) begin
      rx_st_reg <= spm_pkg::RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_cnt_reg <= 3'h0;
      rdiv_reg <= 8'h00;
      rx_ph_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else begin
      rdiv_reg <= rx_ht ? 8'h00 : rdiv_reg + 8'h01;
      if (rx_ht) rx_ph_reg <= !rx_ph_reg;
      case (rx_st_reg)
        spm_pkg::RX_IDLE: begin
          rdiv_reg <= 8'h00;
          rx_ph_reg <= 1'b0;
          rx_cnt_reg <= 3'h0;
          if (ctrl_reg.sync_mode) rx_st_reg <= spm_pkg::RX_DATA;
          else if (!rxd_i) rx_st_reg <= spm_pkg::RX_START;
        end
        spm_pkg::RX_START: if (rx_samp) begin
          rx_st_reg <= rxd_i ? spm_pkg::RX_IDLE : spm_pkg::RX_DATA;
        end
        spm_pkg::RX_DATA: if (rx_samp) begin
          rx_shift_reg <= {rxd_i, rx_shift_reg[7:1]};
          rx_cnt_reg <= rx_cnt_reg + 3'h1;
          if (rx_cnt_reg == spm_pkg::LAST_BIT && !ctrl_reg.sync_mode) begin
            rx_st_reg <= ctrl_reg.parity_enable ? spm_pkg::RX_PAR : spm_pkg::RX_STOP;
          end
        end
        spm_pkg::RX_PAR: if (rx_samp) begin
          rx_perr_reg <= rxd_i ^ (^rx_shift_reg);
          rx_st_reg <= spm_pkg::RX_STOP;
        end
        spm_pkg::RX_STOP: if (rx_samp) begin
          rx_perr_reg <= 1'b0;
          rx_st_reg <= spm_pkg::RX_IDLE;
        end
        default: rx_st_reg <= spm_pkg::RX_IDLE;
      endcase
    end
  end

  // receive holding register
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_act) rx_holding_reg <= 8'h00;
    else if (rx_store) rx_holding_reg <= rx_word;
  end

  // status flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_act) begin
      stat_reg <= spm_pkg::STAT_RST;
    end else begin
      stat_reg.tx_empty_flag <= tx_go || (stat_reg.tx_empty_flag
                                && !sts_clr.tx_empty_flag && !dma_tx_wr);
      stat_reg.tx_end_flag <= (tx_done && stat_reg.tx_empty_flag) || (stat_reg.tx_end_flag
                              && !tx_go && !sts_clr.tx_empty_flag && !dma_tx_wr);
      // dma reads are assumed to come from the rx full request
      stat_reg.rx_full_flag <= rx_store || (stat_reg.rx_full_flag
                               && !sts_clr.rx_full_flag && !dma_rx_rd);
      // error flags ignore rx enable; only a written 0, reset, module stop or low power clears them
      stat_reg.overrun_flag <= (rx_fin && stat_reg.rx_full_flag)
                               || (stat_reg.overrun_flag && !sts_clr.overrun_flag);
      stat_reg.framing_error_flag <= rx_fer_ev
          || (stat_reg.framing_error_flag && !sts_clr.framing_error_flag);
      stat_reg.parity_error_flag <= rx_per_ev
          || (stat_reg.parity_error_flag && !sts_clr.parity_error_flag);
    end
  end

  // sck pulse when the mode bit leaves sync while sck was driven out
  assign glitch_trig = wr_ok && aw_addr_reg == spm_pkg::OFS_CTRL && !lp_act
                       && ctrl_reg.sync_mode && !ctrl_reg.clock_source_select
                       && !wv_ctrl[6] && !wv_ctrl[7];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glitch_reg <= 1'b0;
      glitch_cnt_reg <= 8'h00;
    end else if (glitch_trig) begin
      glitch_reg <= 1'b1;
      glitch_cnt_reg <= baud_reg;
    end else if (glitch_reg) begin
      glitch_reg <= glitch_cnt_reg != 8'h00;
      glitch_cnt_reg <= glitch_cnt_reg - 8'h01;
    end
  end

  // pin muxing: port settings own the pins whenever the unit lets go
  always_comb begin
    if (ctrl_reg.tx_enable_bit && !lp_act) begin
      txd_oe = 1'b1;
      txd_o = tx_line_reg;
    end else begin
      txd_oe = port_reg.port_dir_control;
      txd_o = port_reg.port_output_value;
    end
    if (glitch_reg) begin
      sck_oe = 1'b1;
      sck_o = 1'b0;
    end else if (lp_act || (!ctrl_reg.sync_mode && !ctrl_reg.clock_source_select
                            && !ctrl_reg.clock_output_enable)) begin
      sck_oe = port_reg.sck_dir_control;
      sck_o = port_reg.sck_out_value;
    end else if (ctrl_reg.clock_source_select) begin
      sck_oe = 1'b0;
      sck_o = 1'b1;
    end else begin
      sck_oe = 1'b1;
      sck_o = (tx_st_reg == spm_pkg::TX_IDLE) || tx_ph_reg;
    end
  end

  // requests to the interrupt and dma controllers
  assign tx_empty_request = stat_reg.tx_empty_flag && ctrl_reg.tx_empty_irq_enable;
  assign tx_end_request = stat_reg.tx_end_flag && ctrl_reg.tx_end_irq_enable;
  assign rx_full_request = stat_reg.rx_full_flag && ctrl_reg.rx_irq_enable;
  assign rx_error_request = err_any && ctrl_reg.rx_irq_enable;
  assign dma_rx_data = rx_holding_reg;

  // checks
  default clocking spm_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence mode_leave_s; glitch_trig; endsequence
  sequence sck_low_s; sck_oe && !sck_o; endsequence
  stop_halt_a: assert property (mstop_reg |=> tx_st_reg == spm_pkg::TX_IDLE)
    else $error("engine ran under module stop");
  break_fer_a: assert property (rx_fin && !ctrl_reg.sync_mode && !rxd_i && !lp_act
    |=> stat_reg.framing_error_flag) else $error("break did not set framing flag");
  txd_port_a: assert property (!ctrl_reg.tx_enable_bit |->
    txd_oe == port_reg.port_dir_control && txd_o == port_reg.port_output_value)
    else $error("txd not under port control");
  tx_init_a: assert property ($fell(ctrl_reg.tx_enable_bit)
    |=> tx_st_reg == spm_pkg::TX_IDLE && tx_line_reg) else $error("tx not reset");
  err_block_a: assert property (tx_st_reg == spm_pkg::TX_IDLE && ctrl_reg.sync_mode
    && err_any |=> tx_st_reg == spm_pkg::TX_IDLE) else $error("sync tx started on error");
  flags_keep_a: assert property (err_any && !lp_act && !sts_clr.overrun_flag
    && !sts_clr.parity_error_flag && !sts_clr.framing_error_flag |=> err_any)
    else $error("error flags lost");
  tx_lowpow_a: assert property (lp_act |=> stat_reg == spm_pkg::STAT_RST
    && tx_holding_reg == 8'h00) else $error("tx side not reset in low power");
  mark_exit_a: assert property ($fell(lp_act) |-> tx_line_reg)
    else $error("no mark after low power");
  rx_lowpow_a: assert property (lp_act |=> rx_st_reg == spm_pkg::RX_IDLE
    && rx_holding_reg == 8'h00) else $error("rx side not reset in low power");
  sck_pulse_a: assert property (mode_leave_s |=> sck_low_s)
    else $error("no sck low pulse");
  dma_clear_a: assert property (dma_tx_wr && stat_reg.tx_empty_flag && !lp_act
    |=> !stat_reg.tx_empty_flag) else $error("dma write left tx empty set");
  err_req_a: assert property ($rose(err_any) && ctrl_reg.rx_irq_enable
    |-> rx_error_request) else $error("error request missing");
endmodule : spm_serial_top
`default_nettype wire

// ==== pkg/spm_pkg.sv ====
// package: register map, field layout, reset values and types of the serial port unit
`default_nettype none
package spm_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_STOP = 8'h00; // module stop control
  localparam logic [7:0] OFS_CTRL = 8'h04; // serial control
  localparam logic [7:0] OFS_STAT = 8'h08; // serial_status_reg
  localparam logic [7:0] OFS_TXD = 8'h0c; // tx_holding_reg
  localparam logic [7:0] OFS_RXD = 8'h10; // rx_holding_reg
  localparam logic [7:0] OFS_PORT = 8'h14; // pin port control
  localparam logic [7:0] OFS_BAUD = 8'h18; // half-bit divider
  localparam int CTRL_W = 9; // control field width
  localparam int STAT_W = 6; // status field width
  localparam int PORT_W = 4; // port field width
  localparam logic [7:0] BAUD_RST = 8'h0f; // half bit lasts divider+1 cycles
  localparam logic [2:0] LAST_BIT = 3'h7; // index of the eighth data bit
  localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer: done
  localparam logic [1:0] RESP_SLVERR = 2'h2; // bus answer: refused or unmapped
  // control register, bit 0 first from the bottom
  typedef struct packed {
    logic clock_output_enable; // 8: async bit clock out on sck
    logic clock_source_select; // 7: 1 = sck is an input
    logic sync_mode; // 6: 1 = clocked synchronous
    logic parity_enable; // 5: even parity in async frames
    logic rx_irq_enable; // 4: gates rx full and rx error requests
    logic tx_end_irq_enable; // 3
    logic tx_empty_irq_enable; // 2
    logic rx_enable_bit; // 1
    logic tx_enable_bit; // 0
  } spm_ctrl_s;
  localparam spm_ctrl_s CTRL_RST = spm_ctrl_s'(9'h000);
  // status register
  typedef struct packed {
    logic tx_end_flag; // 5: read only
    logic parity_error_flag; // 4
    logic framing_error_flag; // 3
    logic overrun_flag; // 2
    logic rx_full_flag; // 1
    logic tx_empty_flag; // 0
  } spm_status_s;
  localparam spm_status_s STAT_RST = spm_status_s'(6'h21);
  localparam logic [5:0] STAT_CLR_MASK = 6'h1f; // flags that a written 0 clears
  // port control of the txd and sck pins
  typedef struct packed {
    logic sck_out_value; // 3
    logic sck_dir_control; // 2
    logic port_output_value; // 1: txd level when in port mode
    logic port_dir_control; // 0: txd direction, 1 = drive
  } spm_port_s;
  localparam spm_port_s PORT_RST = spm_port_s'(4'h0);
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } spm_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } spm_rx_e;
endpackage : spm_pkg
`default_nettype wire

// ==== test/spm_remote_model.sv ====
// far-end serial device: holds the receive line at mark or in break
`default_nettype none
module spm_remote_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic brk, // bench asks for a break
  output logic rxd // line toward the unit
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle is mark level; a break is all zeros for as long as it is asked
  always_ff @(posedge aclk) begin
    rxd <= !aresetn || !brk;
  end
endmodule : spm_remote_model
`default_nettype wire

// ==== test/serial_port_mode_handling_tb.sv ====
// self-checking bench of the serial port unit
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module serial_port_mode_handling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic brk = 0, low_power_req = 0, dma_tx_wr = 0, awready, wready, bvalid, arready, rvalid;
  logic tx_empty_request, tx_end_request, rx_full_request, rx_error_request;
  logic txd_o, txd_oe, rxd, sck_o, sck_oe, sck = 1;
  logic [7:0] awaddr = 0, araddr = 0, dma_tx_data = 0, dma_rx_data;
  logic [31:0] wdata = 0, rdata, rdv;
  logic [1:0] bresp, rresp, rs;
  int failures = 0, total_checks = 0;
  always #2 aclk = ~aclk;
  // all byte lanes on; dma never reads rx holding, so no read outruns the rx full request
  spm_serial_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .low_power_req(low_power_req), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
    .dma_rx_rd(1'b0),
    .dma_rx_data(dma_rx_data), .tx_empty_request(tx_empty_request),
    .tx_end_request(tx_end_request), .rx_full_request(rx_full_request),
    .rx_error_request(rx_error_request), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd),
    .sck_i(sck), .sck_o(sck_o), .sck_oe(sck_oe));
  spm_remote_model rm (.aclk(aclk), .aresetn(aresetn), .brk(brk), .rxd(rxd));
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // write: both halves offered together, each dropped once taken, answer held until seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 0;
    if (n == 99) begin failures++; results(); end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    {rs, rdv} = {rresp, rdata};
    rready <= 0;
    if (n == 99) begin failures++; results(); end
  endtask : rd
  task automatic t_stop;
    rd(spm_pkg::OFS_CTRL);
    `CHK("stopped", spm_pkg::RESP_SLVERR, rs)
    wr(spm_pkg::OFS_STOP, 0);
    `CHK("stop wr", spm_pkg::RESP_OKAY, rs)
    rd(spm_pkg::OFS_CTRL);
    `CHK("running", spm_pkg::RESP_OKAY, rs)
    wr(spm_pkg::OFS_PORT, 3);
    `CHK("mark", 2'b11, {txd_oe, txd_o})
    wr(spm_pkg::OFS_PORT, 1);
    `CHK("break out", 2'b10, {txd_oe, txd_o})
    $display("test stop and port done");
  endtask : t_stop
  // a continuous break must keep re-raising the framing flag after software clears it
  task automatic t_break;
    wr(spm_pkg::OFS_CTRL, 32'h12);
    brk <= 1;
    repeat (400) @(posedge aclk);
    wr(spm_pkg::OFS_STAT, 32'h1);
    rd(spm_pkg::OFS_STAT);
    `CHK("fer cleared", 1'b0, rdv[3])
    repeat (400) @(posedge aclk);
    rd(spm_pkg::OFS_STAT);
    `CHK("fer again", 1'b1, rdv[3])
    brk <= 0;
    wr(spm_pkg::OFS_CTRL, 32'h10);
    rd(spm_pkg::OFS_STAT);
    `CHK("fer kept", 1'b1, rdv[3])
    `CHK("err req", 1'b1, rx_error_request)
    $display("test break done");
  endtask : t_break
  // framing flag still set: sync mode must hold the byte back
  task automatic t_sync;
    wr(spm_pkg::OFS_CTRL, 32'h45);
    dma_tx_wr <= 1;
    @(posedge aclk);
    dma_tx_wr <= 0;
    repeat (9) @(posedge aclk);
    rd(spm_pkg::OFS_STAT);
    `CHK("dma empty clr", 1'b0, rdv[0])
    `CHK("tx refused", 1'b0, tx_empty_request)
    low_power_req <= 1;
    repeat (3) @(posedge aclk);
    `CHK("lp pin", 2'b10, {txd_oe, txd_o})
    low_power_req <= 0;
    wr(spm_pkg::OFS_CTRL, 32'h47);
    rd(spm_pkg::OFS_STAT);
    `CHK("lp status", 32'(spm_pkg::STAT_RST), rdv)
    `CHK("lp exit", 2'b11, {txd_oe, txd_o})
    wr(spm_pkg::OFS_TXD, 32'h5a);
    wr(spm_pkg::OFS_STAT, 0);
    @(posedge aclk);
    `CHK("resume", 2'b00, {sck_o, txd_o})
    repeat (300) @(posedge aclk);
    `CHK("sync rx", 8'hff, dma_rx_data)
    $display("test sync and low power done");
  endtask : t_sync
  // async byte under way, then tx enable cleared mid-frame
  task automatic t_abort;
    wr(spm_pkg::OFS_PORT, 3);
    wr(spm_pkg::OFS_CTRL, 1);
    `CHK("sck pulse", 2'b10, {sck_oe, sck_o})
    dma_tx_wr <= 1;
    @(posedge aclk);
    dma_tx_wr <= 0;
    repeat (8) @(posedge aclk);
    `CHK("start bit", 1'b0, txd_o)
    wr(spm_pkg::OFS_CTRL, 0);
    `CHK("abort pin", 1'b1, txd_o)
    wr(spm_pkg::OFS_CTRL, 1);
    `CHK("no resume", 1'b1, txd_o)
    dma_tx_wr <= 1;
    @(posedge aclk);
    dma_tx_wr <= 0;
    repeat (8) @(posedge aclk);
    wr(spm_pkg::OFS_PORT, 1);
    wr(spm_pkg::OFS_CTRL, 0);
    `CHK("break pin", 2'b10, {txd_oe, txd_o})
    $display("test abort done");
  endtask : t_abort
  // sync send on external sck, first falling edge well after the dma write
  task automatic t_ext;
    logic [7:0] d = 8'ha5;
    wr(spm_pkg::OFS_CTRL, 32'hc9);
    {dma_tx_data, dma_tx_wr} <= {d, 1'b1};
    @(posedge aclk);
    dma_tx_wr <= 0;
    repeat (5) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      `CHK("ext bit", d[i], txd_o)
      sck <= 0;
      @(posedge aclk);
      sck <= 1;
      @(posedge aclk);
    end
    `CHK("ext end", 2'b11, {tx_end_request, txd_o})
    wr(spm_pkg::OFS_CTRL, 32'h40);
    wr(spm_pkg::OFS_CTRL, 32'hc0);
    wr(spm_pkg::OFS_CTRL, 32'h80);
    `CHK("no sck pulse", 1'b0, sck_oe)
    $display("test ext done");
  endtask : t_ext
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_stop();
    t_break();
    t_sync();
    t_abort();
    t_ext();
    results();
  end
endmodule : serial_port_mode_handling_tb
`default_nettype wire
